// ---- ulp_link_port.sv ----
`timescale 1ns/10ps
`default_nettype none

module ulp_link_port (
  input  wire logic                            CLK,
  input  wire logic                            NRST,
  input  wire logic                            CE,
  input  wire logic [ulp_pkg::ULP_DATA_W-1:0]  TX_DATA,
  input  wire logic                            TX_LAST,
  input  wire logic                            TX_VALID,
  output var  logic                            TX_READY,
  output var  logic [ulp_pkg::ULP_DATA_W-1:0]  RX_DATA,
  output var  logic                            RX_CMD,
  output var  logic                            RX_VALID,
  input  wire logic                            ULPI_CLK,
  input  wire logic                            ULPI_DIR,
  input  wire logic                            ULPI_NXT,
  input  wire logic [ulp_pkg::ULP_DATA_W-1:0]  ULPI_DATA_I,
  output var  logic [ulp_pkg::ULP_DATA_W-1:0]  ULPI_DATA_O,
  output var  logic                            ULPI_DATA_OE,
  output var  logic                            ULPI_STP
);
  import ulp_pkg::*;

  localparam int unsigned WW = ULP_DATA_W + 1;  // data plus last flag

  // ----------------------------------------------------------------
  // transmit buffer, system clock side
  // ----------------------------------------------------------------
  ulp_fifo_if #(.W(WW)) fq ();

  assign fq.wr_valid = TX_VALID;
  assign fq.wr_data  = {TX_LAST, TX_DATA};
  assign TX_READY    = fq.wr_ready;

  ulp_fifo #(.W(WW), .DEPTH(ULP_FIFO_DEPTH)) u_fifo (
    .CLK  (CLK),
    .NRST (NRST),
    .CE   (CE),
    .port (fq.fifo)
  );

  // ----------------------------------------------------------------
  // system side of both crossings
  // ----------------------------------------------------------------
  logic          tx_req_q,  tx_req_d;    // toggles once per word offered
  logic [WW-1:0] tx_hold_q, tx_hold_d;   // word held stable across the crossing
  logic          tx_ack_s1, tx_ack_s2;   // link acknowledge, two flops
  logic          rx_tgl_s1, rx_tgl_s2;   // link receive toggle, two flops
  logic          rx_seen_q, rx_seen_d;   // last receive toggle consumed
  // link registers read here, declared ahead of their first use
  logic          lk_seen_q, lk_seen_d;   // offers staged, returned as acknowledge
  logic [ULP_DATA_W-1:0] lk_rx_byte_q, lk_rx_byte_d;  // last byte taken off the bus
  logic          lk_rx_cmd_q, lk_rx_cmd_d;      // that byte came with next low
  logic          lk_rx_tgl_q, lk_rx_tgl_d;      // flips once per captured byte
  logic [ULP_DATA_W-1:0] rx_data_d;
  logic          rx_cmd_d, rx_valid_d;
  logic          take;

  // one word in flight: the next pop waits for the link to acknowledge
  always_comb begin
    take       = fq.rd_valid && (tx_req_q == tx_ack_s2);
    fq.rd_ready = take;
    tx_req_d   = tx_req_q ^ take;
    tx_hold_d  = take ? fq.rd_data : tx_hold_q;
    rx_valid_d = (rx_tgl_s2 != rx_seen_q);
    rx_seen_d  = rx_tgl_s2;
    rx_data_d  = rx_valid_d ? lk_rx_byte_q : RX_DATA;
    rx_cmd_d   = rx_valid_d ? lk_rx_cmd_q  : RX_CMD;
  end

  // system registers; the receive byte is stable while its toggle settles
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_req_q  <= 1'b0;
      tx_hold_q <= '0;
      tx_ack_s1 <= 1'b0;
      tx_ack_s2 <= 1'b0;
      rx_tgl_s1 <= 1'b0;
      rx_tgl_s2 <= 1'b0;
      rx_seen_q <= 1'b0;
      RX_DATA   <= '0;
      RX_CMD    <= 1'b0;
      RX_VALID  <= 1'b0;
    end else if (CE) begin
      tx_req_q  <= tx_req_d;
      tx_hold_q <= tx_hold_d;
      tx_ack_s1 <= lk_seen_q;
      tx_ack_s2 <= tx_ack_s1;
      rx_tgl_s1 <= lk_rx_tgl_q;
      rx_tgl_s2 <= rx_tgl_s1;
      rx_seen_q <= rx_seen_d;
      RX_DATA   <= rx_data_d;
      RX_CMD    <= rx_cmd_d;
      RX_VALID  <= rx_valid_d;
    end
  end

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  // port timed by link clock
  logic          lk_rst_s1, lk_rst_n;             // reset brought onto the link clock
  ulp_state_e    lk_st_q, lk_st_d;                // sequencer state
  logic          lk_dir_q, lk_dir_d;              // direction seen last cycle
  logic          lk_req_s1, lk_req_s2;            // offer toggle, two flops
  logic [WW-1:0] lk_nb_q, lk_nb_d;                // staged next byte
  logic          lk_nb_vld_q, lk_nb_vld_d;
  logic          lk_last_q, lk_last_d;            // byte on the bus ends the stream
  logic [ULP_DATA_W-1:0] lk_dat_d;
  logic          lk_oe_d, lk_stp_d;
  logic          lk_turn, lk_own;

  // link sequencer next state
  always_comb begin
    lk_st_d      = lk_st_q;
    lk_dir_d     = ULPI_DIR;
    lk_seen_d    = lk_seen_q;
    lk_nb_d      = lk_nb_q;
    lk_nb_vld_d  = lk_nb_vld_q;
    lk_last_d    = lk_last_q;
    lk_dat_d     = ULPI_DATA_O;
    lk_stp_d     = 1'b0;
    lk_rx_byte_d = lk_rx_byte_q;
    lk_rx_cmd_d  = lk_rx_cmd_q;
    lk_rx_tgl_d  = lk_rx_tgl_q;
    lk_turn      = (ULPI_DIR != lk_dir_q);
    lk_own       = !ULPI_DIR && !lk_dir_q;
    lk_oe_d      = lk_own;
    // stage a word from the system side when the slot is free
    if ((lk_req_s2 != lk_seen_q) && !lk_nb_vld_q) begin
      lk_nb_d     = tx_hold_q;
      lk_nb_vld_d = 1'b1;
      lk_seen_d   = lk_req_s2;
    end
    if (ULPI_DIR && lk_dir_q) begin
      lk_rx_byte_d = ULPI_DATA_I;
      lk_rx_cmd_d  = !ULPI_NXT;
      lk_rx_tgl_d  = !lk_rx_tgl_q;
    end
    case (lk_st_q)
      ULP_ST_IDLE: begin
        lk_dat_d = ULP_IDLE_BYTE;
        if (lk_own && lk_nb_vld_q) begin
          lk_dat_d    = lk_nb_q[ULP_DATA_W-1:0];
          lk_last_d   = lk_nb_q[WW-1];
          lk_nb_vld_d = 1'b0;
          lk_st_d     = ULP_ST_TX;
        end
      end
      ULP_ST_TX: begin
        if (lk_own && !lk_turn && ULPI_NXT) begin
          if (lk_last_q) begin
            lk_stp_d = 1'b1;
            lk_dat_d = ULP_IDLE_BYTE;
            lk_st_d  = ULP_ST_STOP;
          end else if (lk_nb_vld_q) begin
            lk_dat_d    = lk_nb_q[ULP_DATA_W-1:0];
            lk_last_d   = lk_nb_q[WW-1];
            lk_nb_vld_d = 1'b0;
          end else begin
            // underrun: the port cannot stall after next, so abort
            lk_stp_d = 1'b1;
            lk_dat_d = ULP_ABORT_BYTE;
            lk_st_d  = ULP_ST_STOP;
          end
        end
      end
      ULP_ST_STOP: begin
        lk_dat_d = ULP_IDLE_BYTE;
        lk_st_d  = ULP_ST_IDLE;
      end
      default: begin
        lk_dat_d = ULP_IDLE_BYTE;
        lk_st_d  = ULP_ST_IDLE;
      end
    endcase
  end

  // link registers; the reset synchroniser flops carry no reset themselves
  always_ff @(posedge ULPI_CLK) begin
    lk_rst_s1 <= NRST;
    lk_rst_n  <= lk_rst_s1;
    lk_req_s1 <= tx_req_q;
    lk_req_s2 <= lk_req_s1;
    if (!lk_rst_n) begin
      lk_st_q      <= ULP_ST_IDLE;
      lk_dir_q     <= ULP_RST_DIR;
      lk_seen_q    <= 1'b0;
      lk_nb_q      <= '0;
      lk_nb_vld_q  <= 1'b0;
      lk_last_q    <= 1'b0;
      lk_rx_byte_q <= '0;
      lk_rx_cmd_q  <= 1'b0;
      lk_rx_tgl_q  <= 1'b0;
      ULPI_DATA_O  <= ULP_IDLE_BYTE;
      ULPI_DATA_OE <= ULP_RST_OE;
      ULPI_STP     <= ULP_RST_STP;
    end else begin
      lk_st_q      <= lk_st_d;
      lk_dir_q     <= lk_dir_d;
      lk_seen_q    <= lk_seen_d;
      lk_nb_q      <= lk_nb_d;
      lk_nb_vld_q  <= lk_nb_vld_d;
      lk_last_q    <= lk_last_d;
      lk_rx_byte_q <= lk_rx_byte_d;
      lk_rx_cmd_q  <= lk_rx_cmd_d;
      lk_rx_tgl_q  <= lk_rx_tgl_d;
      ULPI_DATA_O  <= lk_dat_d;
      ULPI_DATA_OE <= lk_oe_d;
      ULPI_STP     <= lk_stp_d;
    end
  end

  // ----------------------------------------------------------------
  // checks on the link side
  // ----------------------------------------------------------------
  sequence s_last_taken;
    lk_st_q == ULP_ST_TX && lk_last_q && ULPI_NXT && !ULPI_DIR && !lk_dir_q;
  endsequence

  sequence s_stop_pulse;
    ULPI_STP && ULPI_DATA_O == ULP_IDLE_BYTE ##1 !ULPI_STP;
  endsequence

  chk_stop_after_last: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    s_last_taken |=> s_stop_pulse)
    else $error("no single stop after last byte");

  chk_stop_width: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    $rose(ULPI_STP) |=> !ULPI_STP)
    else $error("stop held longer than one cycle");

  chk_idle_low: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    (lk_st_q == ULP_ST_IDLE && ULPI_DATA_OE) |-> ULPI_DATA_O == ULP_IDLE_BYTE)
    else $error("idle bus not driven low");

  chk_dir_owner: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    ULPI_DIR |=> !ULPI_DATA_OE)
    else $error("link drives while transceiver owns bus");

  chk_turn_quiet: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    $fell(ULPI_DIR) |=> !ULPI_DATA_OE ##1 (ULPI_DIR || ULPI_DATA_OE))
    else $error("turnaround cycle wrong after direction fall");

  chk_advance_nxt: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    (lk_st_q == ULP_ST_TX && $past(lk_st_q) == ULP_ST_TX && ULPI_DATA_O != $past(ULPI_DATA_O))
      |-> $past(ULPI_NXT))
    else $error("stream advanced without next");

  chk_rx_capture: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    (ULPI_DIR && lk_dir_q) |=> lk_rx_tgl_q != $past(lk_rx_tgl_q) && lk_rx_byte_q == $past(ULPI_DATA_I))
    else $error("received byte not captured");

  chk_rx_hold_turn: assert property (@(posedge ULPI_CLK) disable iff (!lk_rst_n)
    (ULPI_DIR != lk_dir_q) |=> $stable(lk_rx_tgl_q))
    else $error("byte captured in turnaround");

endmodule : ulp_link_port

`default_nettype wire

// ---- ulp_pkg.sv ----
`default_nettype none

package ulp_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int unsigned ULP_DATA_W     = 8;   // link data bus width
  localparam int unsigned ULP_FIFO_DEPTH = 16;  // transmit buffer words

  // ----------------------------------------------------------------
  // bus values
  // ----------------------------------------------------------------
  localparam logic [7:0] ULP_IDLE_BYTE  = 8'h00; // idle bus level, also driven with stop
  localparam logic [7:0] ULP_ABORT_BYTE = 8'hff; // driven with stop on a transmit underrun

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic       ULP_RST_OE  = 1'b0;   // link starts with drivers off
  localparam logic       ULP_RST_STP = 1'b0;   // no stop pending
  localparam logic       ULP_RST_DIR = 1'b1;   // assume the transceiver owns the bus

  // ----------------------------------------------------------------
  // link-side sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ULP_ST_IDLE = 3'b001,  // bus parked low, waiting for a byte
    ULP_ST_TX   = 3'b010,  // streaming bytes, paced by next
    ULP_ST_STOP = 3'b100   // one-cycle stop strobe
  } ulp_state_e;

endpackage : ulp_pkg

`default_nettype wire

// ---- ulp_fifo_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// valid/ready stream carrier around the transmit buffer
interface ulp_fifo_if #(
  parameter int unsigned W = 9
);
  logic         wr_valid;  // producer has a word
  logic         wr_ready;  // buffer can take a word
  logic [W-1:0] wr_data;   // word in
  logic         rd_valid;  // buffer has a word
  logic         rd_ready;  // consumer takes the word
  logic [W-1:0] rd_data;   // word out

  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : ulp_fifo_if

`default_nettype wire

// ---- ulp_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module ulp_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  ulp_fifo_if.fifo  port
);
  import ulp_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = AW'(0) | (AW+1)'(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0]  mem [DEPTH];          // word store
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;   // next slot to fill
  logic [AW-1:0] rd_ptr_q, rd_ptr_d;   // oldest word
  logic [AW:0]   count_q,  count_d;    // words held
  logic          ready_q,  ready_d;    // registered not-full
  logic          push, pop;

  assign port.wr_ready = ready_q;
  assign port.rd_valid = (count_q != '0);
  assign port.rd_data  = mem[rd_ptr_q];

  // next pointers; ready is registered so the top can drive it from a flop
  always_comb begin
    push     = port.wr_valid && ready_q;
    pop      = port.rd_ready && (count_q != '0);
    wr_ptr_d = push ? AW'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
    rd_ptr_d = pop  ? AW'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
    count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
    ready_d  = (count_d != FULL_CNT);
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
    end else if (CE) begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
      if (push) begin
        mem[wr_ptr_q] <= port.wr_data;
      end
    end
  end

  chk_fifo_bound: assert property (@(posedge CLK) disable iff (!NRST)
    count_q <= FULL_CNT && (ready_q == (count_q != FULL_CNT)))
    else $error("fifo count out of range or ready wrong");

endmodule : ulp_fifo

`default_nettype wire

// ---- ulp_phy_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// behavioural transceiver facing the link port
module ulp_phy_model (
  input  wire logic       ULPI_CLK,
  input  wire logic [7:0] DATA_O,
  input  wire logic       DATA_OE,
  input  wire logic       STP,
  output var  logic       DIR,
  output var  logic       NXT,
  output var  logic [7:0] DATA_I
);
  // ----------------------------------------------------------------
  // model state
  // ----------------------------------------------------------------
  logic [7:0] drv_data  = 8'h00;  // byte the transceiver puts out
  logic       drv_on    = 1'b0;   // transceiver drives the data lines
  logic       own       = 1'b0;   // a scripted sequence is in charge
  logic [7:0] bus_q     = 8'h00;  // last bus level, shown inverted when floating
  logic       dir_p1    = 1'b0;   // direction one edge back
  logic       dir_p2    = 1'b0;   // direction two edges back
  logic       stp_p     = 1'b0;   // stop one edge back
  int         gap       = 12;     // idle cycles before each next
  int         wait_n    = 0;      // cycles waited so far
  int         conflicts = 0;      // link drove when it had to be quiet
  int         dbl_stops = 0;      // stop longer than one cycle
  logic [7:0] got_q[$];           // bytes taken from the link
  logic [7:0] stop_q[$];          // bus value seen with each stop

  initial begin
    DIR = 1'b0;
    NXT = 1'b0;
  end

  // direction picks the driver, floating bus keeps moving
  assign DATA_I = DIR ? (drv_on ? drv_data : ~bus_q) : (DATA_OE ? DATA_O : ~bus_q);

  // all sampling on the transceiver clock
  always @(posedge ULPI_CLK) begin
    bus_q  <= DATA_I;
    dir_p1 <= DIR;
    dir_p2 <= dir_p1;
    stp_p  <= STP;
    // link quiet while and just after the transceiver owns the bus
    if (DATA_OE && (dir_p1 || dir_p2)) begin
      conflicts++;
    end
    // stop one cycle, logged with its bus value
    if (STP) begin
      stop_q.push_back(DATA_O);
      if (stp_p) begin
        dbl_stops++;
      end
    end
    // a byte moves only on a next cycle
    if (!DIR && !dir_p1 && DATA_OE && NXT && !STP) begin
      got_q.push_back(DATA_O);
    end
    // throttle, next raised after a gap; idle byte never acknowledged
    if (!own) begin
      if (NXT || STP || !DATA_OE || DIR || DATA_O == 8'h00) begin
        NXT    <= #1 1'b0;
        wait_n <= 0;
      end else if (wait_n >= gap) begin
        NXT <= #1 1'b1;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end

  // receive one byte, turnaround on either side
  task automatic send_rx(input logic [7:0] b, input logic cmd);
    own = 1'b1;
    @(posedge ULPI_CLK);
    #1 DIR = 1'b1;
    NXT = 1'b0;
    @(posedge ULPI_CLK);
    #1 drv_on = 1'b1;
    drv_data = b;
    NXT = ~cmd;
    @(posedge ULPI_CLK);
    #1 drv_on = 1'b0;
    NXT = 1'b0;
    DIR = 1'b0;
    @(posedge ULPI_CLK);
    #1 own = 1'b0;
  endtask : send_rx

  // take or give back the bus for a long stretch
  task automatic hold_bus(input logic h);
    own = 1'b1;
    @(posedge ULPI_CLK);
    #1 DIR = h;
    NXT = 1'b0;
    repeat (2) @(posedge ULPI_CLK);
    #1 own = h;
  endtask : hold_bus
endmodule : ulp_phy_model

`default_nettype wire

// ---- ulp_link_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module ulp_link_port_tb_top;
  import ulp_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk      = 1'b0;  // system clock
  logic       ulpi_clk = 1'b0;  // link clock
  logic       nrst     = 1'b0;  // reset, low at start
  logic       ce       = 1'b1;  // clock enable
  logic [7:0] tx_data  = 8'h00; // byte offered
  logic       tx_last  = 1'b0;  // final byte marker
  logic       tx_valid = 1'b0;  // offer strobe
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_cmd;
  logic       rx_valid;
  logic       dir;
  logic       nxt;
  logic [7:0] data_i;
  logic [7:0] data_o;
  logic       data_oe;
  logic       stp;
  int         mismatches      = 0;
  int         samples_checked = 0;
  int         cycles          = 0;  // timeout counter
  int         rx_pulses       = 0;  // receive strobes seen
  logic [7:0] exp_q[$];             // bytes the transceiver should get

  ulp_link_port uut (.CLK(clk), .NRST(nrst), .CE(ce), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_CMD(rx_cmd),
    .RX_VALID(rx_valid), .ULPI_CLK(ulpi_clk), .ULPI_DIR(dir), .ULPI_NXT(nxt),
    .ULPI_DATA_I(data_i), .ULPI_DATA_O(data_o), .ULPI_DATA_OE(data_oe), .ULPI_STP(stp));

  ulp_phy_model phy (.ULPI_CLK(ulpi_clk), .DATA_O(data_o), .DATA_OE(data_oe), .STP(stp),
    .DIR(dir), .NXT(nxt), .DATA_I(data_i));

  // ----------------------------------------------------------------
  // clocks, timeout
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  // offset so link edges drift against system edges
  initial begin
    #13;
    forever #32 ulpi_clk = ~ulpi_clk;
  end
  // count strobes; a hang ends the run
  always @(posedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_pulses++;
    end
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // holds the offer up until taken; caller lowers it
  task automatic wr_byte(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    tx_data  = d;
    tx_last  = l;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wr_byte

  // compares what crossed the link once the stream has drained
  task automatic check_q(input int gap);
    int k;
    k = 0;
    while (phy.got_q.size() < exp_q.size() && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (10) @(posedge clk);
    check(8'(phy.got_q.size()), 8'(exp_q.size()));
    for (k = 0; k < exp_q.size() && k < phy.got_q.size(); k++) begin
      check(phy.got_q[k], exp_q[k]);
    end
    for (k = 0; k < phy.stop_q.size(); k++) begin
      check(phy.stop_q[k] === ULP_ABORT_BYTE ? ULP_IDLE_BYTE : phy.stop_q[k], ULP_IDLE_BYTE);
    end
    check(phy.stop_q[$], ULP_IDLE_BYTE);
    if (gap > 0) begin
      check(8'(phy.stop_q.size()), 8'h01);
    end
    check(8'(phy.dbl_stops), 8'h00);
    check(8'(phy.conflicts), 8'h00);
    check(data_o, ULP_IDLE_BYTE);
    check({7'h00, data_oe}, 8'h01);
  endtask : check_q

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge clk);
    check({7'h00, data_oe}, 8'h00);
    check({7'h00, stp}, 8'h00);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk);
    check({7'h00, tx_ready}, 8'h01);
    check({7'h00, rx_valid}, 8'h00);
    check(data_o, ULP_IDLE_BYTE);
    check({7'h00, data_oe}, 8'h01);
  endtask : t_reset

  // gap 0 is faster than the crossing, so aborts with ff may split it
  task automatic run_stream(input int n, input int gap);
    int k;
    @(posedge clk);
    #1 phy.gap = gap;
    phy.got_q.delete();
    phy.stop_q.delete();
    exp_q.delete();
    for (k = 0; k < n; k++) begin
      exp_q.push_back(8'h41 + 8'(k));
      wr_byte(8'h41 + 8'(k), logic'(k == n - 1));
    end
    tx_valid = 1'b0;
    check_q(gap);
  endtask : run_stream

  task automatic t_rx(input logic [7:0] b, input logic cmd);
    int k;
    rx_pulses = 0;
    fork
      phy.send_rx(b, cmd);
      begin
        k = 0;
        while (rx_valid !== 1'b1 && k < 40) begin
          @(posedge clk);
          k++;
        end
        check(rx_data, b);
        check({7'h00, rx_cmd}, {7'h00, cmd});
      end
    join
    repeat (10) @(posedge clk);
    check(8'(rx_pulses), 8'h01);
    check(8'(phy.conflicts), 8'h00);
  endtask : t_rx

  // transceiver takes the bus in mid-stream; the byte on the bus must wait
  task automatic t_mid_rx;
    int k;
    @(posedge clk);
    #1 phy.gap = 12;
    phy.got_q.delete();
    phy.stop_q.delete();
    exp_q = '{8'h51, 8'h52};
    wr_byte(8'h51, 1'b0);
    wr_byte(8'h52, 1'b1);
    tx_valid = 1'b0;
    k = 0;
    while (data_o !== 8'h51 && k < 40) begin
      @(posedge clk);
      k++;
    end
    rx_pulses = 0;
    phy.send_rx(8'h33, 1'b1);
    check(data_o, 8'h51);
    check_q(12);
    check(rx_data, 8'h33);
    check(8'(rx_pulses), 8'h01);
  endtask : t_mid_rx

  // transceiver keeps the bus, so the buffer fills until it refuses
  task automatic t_fill;
    int k;
    phy.hold_bus(1'b1);
    @(posedge clk);
    #1 ce = 1'b0;
    tx_data  = 8'h3c;
    tx_last  = 1'b0;
    tx_valid = 1'b1;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    tx_data = 8'h60;
    exp_q.delete();
    phy.got_q.delete();
    phy.stop_q.delete();
    k = 0;
    while (k < 40) begin
      @(posedge clk);
      k++;
      if (tx_ready !== 1'b1) begin
        break;
      end
      exp_q.push_back(tx_data);
      #1 tx_data = tx_data + 8'h01;
    end
    repeat (3) @(posedge clk);
    check({7'h00, tx_ready}, 8'h00);
    check(8'(exp_q.size() >= ULP_FIFO_DEPTH), 8'h01);
    check({7'h00, data_oe}, 8'h00);
    #1 tx_valid = 1'b0;
    phy.gap = 12;
    phy.hold_bus(1'b0);
    @(posedge clk);
    #1;
    exp_q.push_back(8'h7e);
    wr_byte(8'h7e, 1'b1);
    tx_valid = 1'b0;
    check_q(12);
  endtask : t_fill

  // ----------------------------------------------------------------
  // run and verdict
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    t_reset();
    run_stream(1, 12);
    run_stream(3, 12);
    run_stream(4, 0);
    t_rx(8'h5a, 1'b1);
    t_rx(8'ha5, 1'b0);
    t_mid_rx();
    t_fill();
    close_out();
  end
endmodule : ulp_link_port_tb_top

`default_nettype wire
